/* File: rtl/sgm_top.v */
// safety gate monitor: evaluation, faults, reset sequences, function test
`timescale 1ns/1ps
`default_nettype none
`include "sgm_defs.vh"
// Behaviour
// - equivalent one pair: both contacts on
// - complementary one pair: NC on, NO off
// - equivalent two pairs: all four on
// - complementary two pairs: 1,3 on; 2,4 off
// - any error forces permission off, flags fault
// - pair discrepancy raises that pair's mismatch fault
// - test not done between triggers: test fail
// - two pairs: time skew, raise skew fault
// - no test: off-then-on or restart clears
// - test pending: on-off-on gate test clears
// - test not pending: off-then-on clears error
// - two pairs: both off then on clears
// - errors reported separately, evaluation continues
// - test enabled: open and close before permission
// - restart with test enabled needs gate test
// - separate enables for optional outputs, fault
// - discrepancy limit 0..30 s, 10 ms, 30 ms
// - sync limit 0..30 s, 10 ms, 300 ms
// - start: clear errors, reset timers
module sgm_top #(
  parameter TICK_CYCLES = `SGM_TICK_MS * `SGM_CLK_KHZ
) (
  input wire SYS_CLK_I,
  input wire RESET_I,
  input wire [3:0] GATE_IN_I,
  input wire RUN_MODE_I,
  input wire TEST_TRIG_I,
  input wire [`SGM_ADDR_W-1:0] ADDR_I,
  input wire [`SGM_DATA_W-1:0] WDATA_I,
  input wire WR_I,
  input wire RD_I,
  output wire [`SGM_DATA_W-1:0] RDATA_O,
  output wire GATE_OK_O,
  output wire FAULT_O,
  output wire P1_MISMATCH_O,
  output wire P2_MISMATCH_O,
  output wire TEST_PENDING_O,
  output wire SKEW_FAULT_O,
  output wire TEST_FAIL_O
);
  // tick period cut to the counter width on purpose; the default fits it
  localparam integer TICK_LAST_INT = TICK_CYCLES - 1;
  localparam [`SGM_TICK_W-1:0] TICK_LAST = TICK_LAST_INT[`SGM_TICK_W-1:0];

  function [3:0] test_step;
    input [3:0] cur;
    input start;
    input act;
    input inact;
    begin
      if (start) begin
        test_step = act ? `SGM_ST_WOPEN : `SGM_ST_WCLOSE;
      end else begin
        case (cur)
          `SGM_ST_WCLOSE: test_step = act ? `SGM_ST_WOPEN : cur;
          `SGM_ST_WOPEN: test_step = inact ? `SGM_ST_WRECL : cur;
          `SGM_ST_WRECL: test_step = act ? `SGM_ST_DONE : cur;
          `SGM_ST_DONE: test_step = cur;
          default: test_step = `SGM_ST_WCLOSE;
        endcase
      end
    end
  endfunction

  // configuration registers
  reg [`SGM_CTRL_W-1:0] ctrl_reg;
  reg [`SGM_TMR_W-1:0] disc1_reg;
  reg [`SGM_TMR_W-1:0] disc2_reg;
  reg [`SGM_TMR_W-1:0] sync_reg;
  reg [`SGM_DATA_W-1:0] rdata_reg;

  // state
  reg [`SGM_TICK_W-1:0] tick_cnt_reg;
  reg run_prev_reg;
  reg mis1_reg;
  reg mis2_reg;
  reg skew_reg;
  reg tfail_reg;
  reg pend_reg;
  reg trig_wait_reg;
  reg seen_inact_reg;
  reg sync_arm_reg;
  reg gate_ok_reg;
  reg [3:0] ts1_reg;
  reg [3:0] ts2_reg;

  reg mis1_next;
  reg mis2_next;
  reg skew_next;
  reg tfail_next;
  reg pend_next;
  reg trig_wait_next;
  reg seen_inact_next;
  reg sync_arm_next;
  reg gate_ok_next;
  reg [3:0] ts1_next;
  reg [3:0] ts2_next;
  reg [`SGM_DATA_W-1:0] rdata_next;

  wire [2:0] in_type = ctrl_reg[`SGM_CTRL_TYPE_MSB:`SGM_CTRL_TYPE_LSB];
  wire fte = ctrl_reg[`SGM_CTRL_FTE];
  // free-running tick, so a limit may expire up to one tick early
  wire tick = (tick_cnt_reg == TICK_LAST);
  wire run_rise = RUN_MODE_I && !run_prev_reg;

  wire two_pair = (in_type == `SGM_TYPE_EQU2) || (in_type == `SGM_TYPE_CMP2);
  wire cmp_type = (in_type == `SGM_TYPE_CMP1) || (in_type == `SGM_TYPE_CMP2);
  wire single = (in_type == `SGM_TYPE_SINGLE);

  // contact 2 and 4 are read inverted for complementary wiring
  wire c2 = cmp_type ? !GATE_IN_I[1] : GATE_IN_I[1];
  wire c4 = cmp_type ? !GATE_IN_I[3] : GATE_IN_I[3];
  wire p1_act = single ? GATE_IN_I[0] : (GATE_IN_I[0] && c2);
  wire p1_inact = single ? !GATE_IN_I[0] : (!GATE_IN_I[0] && !c2);
  wire p2_act = GATE_IN_I[2] && c4;
  wire p2_inact = !GATE_IN_I[2] && !c4;
  wire p1_disc = !p1_act && !p1_inact;
  wire p2_disc = two_pair && !p2_act && !p2_inact;
  wire all_act = p1_act && (!two_pair || p2_act);
  wire all_inact = p1_inact && (!two_pair || p2_inact);

  wire disc1_exp;
  wire disc2_exp;
  wire sync_exp;
  // timers restart on start of operation
  wire tmr_ok = RUN_MODE_I && !run_rise;
  wire sync_run = tmr_ok && two_pair && sync_arm_reg && (p1_act ^ p2_act);

  sgm_timer u_disc1 (
    .clk_i(SYS_CLK_I),
    .rst_i(RESET_I),
    .run_i(tmr_ok && p1_disc),
    .tick_i(tick),
    .limit_i(disc1_reg),
    .expired_o(disc1_exp)
  );

  sgm_timer u_disc2 (
    .clk_i(SYS_CLK_I),
    .rst_i(RESET_I),
    .run_i(tmr_ok && p2_disc),
    .tick_i(tick),
    .limit_i(disc2_reg),
    .expired_o(disc2_exp)
  );

  sgm_timer u_sync (
    .clk_i(SYS_CLK_I),
    .rst_i(RESET_I),
    .run_i(sync_run),
    .tick_i(tick),
    .limit_i(sync_reg),
    .expired_o(sync_exp)
  );

  // raw error state; enables only mask the pins, not the status word
  wire err_any = mis1_reg || mis2_reg || skew_reg || tfail_reg;
  wire cause_gone = !p1_disc && !p2_disc;
  wire test_done = (ts1_reg == `SGM_ST_DONE) && (!two_pair || (ts2_reg == `SGM_ST_DONE));
  wire test_start = (fte && run_rise) || (fte && TEST_TRIG_I && !pend_reg);

  // evaluation of one scan; every flop updates on every clock edge
  always @* begin
    mis1_next = mis1_reg;
    mis2_next = mis2_reg;
    skew_next = skew_reg;
    tfail_next = tfail_reg;
    pend_next = pend_reg;
    trig_wait_next = trig_wait_reg;
    seen_inact_next = seen_inact_reg;
    sync_arm_next = sync_arm_reg;
    ts1_next = ts1_reg;
    ts2_next = ts2_reg;
    gate_ok_next = 1'b0;
    if (!RUN_MODE_I) begin
      pend_next = pend_reg;
    end else if (run_rise) begin
      mis1_next = 1'b0;
      mis2_next = 1'b0;
      skew_next = 1'b0;
      tfail_next = 1'b0;
      trig_wait_next = 1'b0;
      seen_inact_next = 1'b0;
      sync_arm_next = 1'b1;
      pend_next = fte;
      ts1_next = test_step(ts1_reg, 1'b1, p1_act, p1_inact);
      ts2_next = test_step(ts2_reg, 1'b1, p2_act, p2_inact);
    end else begin
      // pairs test on their own, no synchronisation needed
      ts1_next = test_step(ts1_reg, test_start, p1_act, p1_inact);
      ts2_next = test_step(ts2_reg, test_start, p2_act, p2_inact);
      if (all_inact) begin
        sync_arm_next = 1'b1;
      end else if ((p1_act && p2_act) || sync_exp) begin
        sync_arm_next = 1'b0;
      end
      if (err_any && cause_gone && all_inact) begin
        seen_inact_next = 1'b1;
      end
      // clearing first, fresh errors below win over it
      if (err_any && cause_gone) begin
        if (fte && pend_reg) begin
          if (test_done) begin
            mis1_next = 1'b0;
            mis2_next = 1'b0;
            skew_next = 1'b0;
            tfail_next = 1'b0;
            seen_inact_next = 1'b0;
          end
        end else if (seen_inact_reg && all_act) begin
          mis1_next = 1'b0;
          mis2_next = 1'b0;
          skew_next = 1'b0;
          tfail_next = 1'b0;
          seen_inact_next = 1'b0;
        end
      end
      if (pend_reg && test_done) begin
        pend_next = 1'b0;
        trig_wait_next = 1'b0;
      end
      if (fte && TEST_TRIG_I) begin
        // a trigger in the completion cycle still counts as a miss
        if (trig_wait_reg) begin
          tfail_next = 1'b1;
        end
        trig_wait_next = 1'b1;
        pend_next = 1'b1;
      end
      // each source sets its own flag regardless of the others
      if (disc1_exp) begin
        mis1_next = 1'b1;
      end
      if (disc2_exp) begin
        mis2_next = 1'b1;
      end
      if (sync_exp) begin
        skew_next = 1'b1;
      end
      // a new error while no test is pending demands a fresh gate test when testing is on
      if (fte && !pend_reg && ((disc1_exp && !mis1_reg) || (disc2_exp && !mis2_reg) ||
          (sync_exp && !skew_reg) || (tfail_next && !tfail_reg))) begin
        pend_next = 1'b1;
        ts1_next = test_step(ts1_reg, 1'b1, p1_act, p1_inact);
        ts2_next = test_step(ts2_reg, 1'b1, p2_act, p2_inact);
      end
      gate_ok_next = all_act && !(mis1_next || mis2_next || skew_next || tfail_next) &&
                     !(fte && pend_next);
    end
  end

  always @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      tick_cnt_reg <= {`SGM_TICK_W{1'b0}};
      run_prev_reg <= 1'b0;
      mis1_reg <= 1'b0;
      mis2_reg <= 1'b0;
      skew_reg <= 1'b0;
      tfail_reg <= 1'b0;
      pend_reg <= 1'b0;
      trig_wait_reg <= 1'b0;
      seen_inact_reg <= 1'b0;
      sync_arm_reg <= 1'b1;
      gate_ok_reg <= 1'b0;
      ts1_reg <= `SGM_ST_WCLOSE;
      ts2_reg <= `SGM_ST_WCLOSE;
    end else begin
      tick_cnt_reg <= tick ? {`SGM_TICK_W{1'b0}} : tick_cnt_reg + {{(`SGM_TICK_W-1){1'b0}}, 1'b1};
      run_prev_reg <= RUN_MODE_I;
      mis1_reg <= mis1_next;
      mis2_reg <= mis2_next;
      skew_reg <= skew_next;
      tfail_reg <= tfail_next;
      pend_reg <= pend_next;
      trig_wait_reg <= trig_wait_next;
      seen_inact_reg <= seen_inact_next;
      sync_arm_reg <= sync_arm_next;
      gate_ok_reg <= gate_ok_next;
      ts1_reg <= ts1_next;
      ts2_reg <= ts2_next;
    end
  end

  // register port
  always @* begin
    rdata_next = {`SGM_DATA_W{1'b0}};
    if (RD_I) begin
      case (ADDR_I)
        `SGM_OFS_CTRL: rdata_next = {{(`SGM_DATA_W-`SGM_CTRL_W){1'b0}}, ctrl_reg};
        `SGM_OFS_DISC1: rdata_next = {{(`SGM_DATA_W-`SGM_TMR_W){1'b0}}, disc1_reg};
        `SGM_OFS_DISC2: rdata_next = {{(`SGM_DATA_W-`SGM_TMR_W){1'b0}}, disc2_reg};
        `SGM_OFS_SYNC: rdata_next = {{(`SGM_DATA_W-`SGM_TMR_W){1'b0}}, sync_reg};
        `SGM_OFS_STATUS: rdata_next = {9'h000, pend_reg, tfail_reg, skew_reg, mis2_reg,
                                       mis1_reg, err_any, gate_ok_reg};
        default: rdata_next = {`SGM_DATA_W{1'b0}};
      endcase
    end
  end

  // limits above 30 s saturate so the range stays legal
  wire [`SGM_TMR_W-1:0] wr_lim = (WDATA_I[`SGM_TMR_W-1:0] > `SGM_TMR_MAX) ?
                                 `SGM_TMR_MAX : WDATA_I[`SGM_TMR_W-1:0];

  always @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      ctrl_reg <= `SGM_CTRL_RST;
      disc1_reg <= `SGM_DISC_RST;
      disc2_reg <= `SGM_DISC_RST;
      sync_reg <= `SGM_SYNC_RST;
      rdata_reg <= {`SGM_DATA_W{1'b0}};
    end else begin
      rdata_reg <= rdata_next;
      if (WR_I) begin
        case (ADDR_I)
          `SGM_OFS_CTRL: ctrl_reg <= WDATA_I[`SGM_CTRL_W-1:0];
          `SGM_OFS_DISC1: disc1_reg <= wr_lim;
          `SGM_OFS_DISC2: disc2_reg <= wr_lim;
          `SGM_OFS_SYNC: sync_reg <= wr_lim;
          default: ctrl_reg <= ctrl_reg;
        endcase
      end
    end
  end

  assign RDATA_O = rdata_reg;
  assign GATE_OK_O = gate_ok_reg;
  // a disabled pin stays low even while its error is held
  assign FAULT_O = err_any && ctrl_reg[`SGM_CTRL_EN_FAULT];
  assign P1_MISMATCH_O = mis1_reg && ctrl_reg[`SGM_CTRL_EN_MIS1];
  assign P2_MISMATCH_O = mis2_reg && ctrl_reg[`SGM_CTRL_EN_MIS2];
  assign TEST_PENDING_O = pend_reg && ctrl_reg[`SGM_CTRL_EN_PEND];
  assign SKEW_FAULT_O = skew_reg && ctrl_reg[`SGM_CTRL_EN_SKEW];
  assign TEST_FAIL_O = tfail_reg && ctrl_reg[`SGM_CTRL_EN_TFAIL];
endmodule // sgm_top
`default_nettype wire

/* File: rtl/sgm_defs.vh */
// constants for the safety gate monitor
`ifndef SGM_DEFS_VH
`define SGM_DEFS_VH

`define SGM_ADDR_W 4
`define SGM_DATA_W 16
`define SGM_TMR_W 12

`define SGM_OFS_CTRL 4'h0
`define SGM_OFS_DISC1 4'h1
`define SGM_OFS_DISC2 4'h2
`define SGM_OFS_SYNC 4'h3
`define SGM_OFS_STATUS 4'h4

`define SGM_TYPE_SINGLE 3'h0
`define SGM_TYPE_EQU1 3'h1
`define SGM_TYPE_CMP1 3'h2
`define SGM_TYPE_EQU2 3'h3
`define SGM_TYPE_CMP2 3'h4

`define SGM_CTRL_TYPE_LSB 0
`define SGM_CTRL_TYPE_MSB 2
`define SGM_CTRL_FTE 3
`define SGM_CTRL_EN_MIS1 4
`define SGM_CTRL_EN_MIS2 5
`define SGM_CTRL_EN_PEND 6
`define SGM_CTRL_EN_SKEW 7
`define SGM_CTRL_EN_TFAIL 8
`define SGM_CTRL_EN_FAULT 9
`define SGM_CTRL_W 10

`define SGM_CTRL_RST 10'h001
`define SGM_DISC_RST 12'h003
`define SGM_SYNC_RST 12'h01e
`define SGM_TMR_MAX 12'hbb8

`define SGM_TICK_MS 10
`define SGM_CLK_KHZ 125000
`define SGM_TICK_W 21

`define SGM_ST_WCLOSE 4'h1
`define SGM_ST_WOPEN 4'h2
`define SGM_ST_WRECL 4'h4
`define SGM_ST_DONE 4'h8

`endif

/* File: rtl/sgm_timer.v */
// tick-based elapsed timer with zero-means-off limit
`timescale 1ns/1ps
`default_nettype none
`include "sgm_defs.vh"
module sgm_timer (
  input wire clk_i,
  input wire rst_i,
  input wire run_i,
  input wire tick_i,
  input wire [`SGM_TMR_W-1:0] limit_i,
  output wire expired_o
);
  reg [`SGM_TMR_W-1:0] count_reg;
  reg [`SGM_TMR_W-1:0] count_next;

  always @* begin
    count_next = count_reg;
    if (!run_i) begin
      count_next = {`SGM_TMR_W{1'b0}};
    end else if (tick_i && (count_reg != {`SGM_TMR_W{1'b1}})) begin
      count_next = count_reg + {{(`SGM_TMR_W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      count_reg <= {`SGM_TMR_W{1'b0}};
    end else begin
      count_reg <= count_next;
    end
  end

  // a zero limit switches the check off
  assign expired_o = run_i && (limit_i != {`SGM_TMR_W{1'b0}}) && (count_reg >= limit_i);
endmodule // sgm_timer
`default_nettype wire

/* File: tb/sgm_top_asserts.sv */
// port-level assertion checker for the safety gate monitor
`timescale 1ns/1ps
`default_nettype none
`include "sgm_defs.vh"
module sgm_chk (
  input wire logic SYS_CLK_I,
  input wire logic RESET_I,
  input wire logic [3:0] GATE_IN_I,
  input wire logic RUN_MODE_I,
  input wire logic [3:0] ADDR_I,
  input wire logic [15:0] WDATA_I,
  input wire logic WR_I,
  input wire logic GATE_OK_O,
  input wire logic FAULT_O,
  input wire logic P1_MISMATCH_O,
  input wire logic P2_MISMATCH_O,
  input wire logic TEST_PENDING_O,
  input wire logic SKEW_FAULT_O,
  input wire logic TEST_FAIL_O
);
  logic [9:0] ctrl_reg;
  logic act;
  wire [2:0] ty = ctrl_reg[2:0];
  wire two = (ty == `SGM_TYPE_EQU2) || (ty == `SGM_TYPE_CMP2);
  // shadow of the control word, since the checker sees only the ports
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) ctrl_reg <= `SGM_CTRL_RST;
    else if (WR_I && ADDR_I == `SGM_OFS_CTRL) ctrl_reg <= WDATA_I[9:0];
  end
  always_comb begin
    case (ty)
      `SGM_TYPE_SINGLE: act = GATE_IN_I[0];
      `SGM_TYPE_CMP1: act = GATE_IN_I[0] & ~GATE_IN_I[1];
      `SGM_TYPE_EQU2: act = &GATE_IN_I;
      `SGM_TYPE_CMP2: act = GATE_IN_I == 4'h5;
      default: act = GATE_IN_I[0] & GATE_IN_I[1];
    endcase
  end
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (RESET_I);
  sequence s_rise;
    !RUN_MODE_I ##1 RUN_MODE_I;
  endsequence
  sequence s_clean;
    !FAULT_O && !P1_MISMATCH_O && !P2_MISMATCH_O && !SKEW_FAULT_O && !TEST_FAIL_O;
  endsequence
  perm_halted_a: assert property (!RUN_MODE_I |=> !GATE_OK_O)
    else $error("permission while halted");
  err_safe_a: assert property ((FAULT_O || P1_MISMATCH_O || P2_MISMATCH_O || SKEW_FAULT_O ||
    TEST_FAIL_O) |-> !GATE_OK_O) else $error("permission with an error");
  ok_pattern_a: assert property (GATE_OK_O |-> $past(act))
    else $error("permission without active inputs");
  mis_enable_a: assert property ((P1_MISMATCH_O |-> ctrl_reg[4]) and
    (P2_MISMATCH_O |-> ctrl_reg[5])) else $error("mismatch output not enabled");
  opt_enable_a: assert property ((TEST_PENDING_O |-> ctrl_reg[6]) and (SKEW_FAULT_O |->
    ctrl_reg[7]) and (TEST_FAIL_O |-> ctrl_reg[8]) and (FAULT_O |-> ctrl_reg[9]))
    else $error("optional output not enabled");
  mis2_pairs_a: assert property ($rose(P2_MISMATCH_O) |-> two)
    else $error("pair two fault in one-pair mode");
  skew_pairs_a: assert property ($rose(SKEW_FAULT_O) |-> two)
    else $error("skew fault in one-pair mode");
  start_test_a: assert property (s_rise ##0 ctrl_reg[3] |=> !GATE_OK_O [*2])
    else $error("permission before startup test");
  start_clear_a: assert property (s_rise |-> ##[1:2] s_clean)
    else $error("errors kept over start");
endmodule // sgm_chk
`default_nettype wire

/* File: tb/sgm_door.sv */
// contact model of a guard door with one or two switch pairs
`timescale 1ns/1ps
`default_nettype none
module sgm_door (
  input wire logic clk_i,
  input wire logic [1:0] shut_i,
  input wire logic comp_i,
  input wire logic [3:0] bad_i,
  output logic [3:0] gate_o
);
  initial gate_o = 4'h0;
  // contacts move a clock after the command; bad_i inverts single contacts to model faults
  always @(posedge clk_i) begin
    gate_o <= {shut_i[1] ^ comp_i, shut_i[1], shut_i[0] ^ comp_i, shut_i[0]} ^ bad_i;
  end
endmodule // sgm_door
`default_nettype wire

/* File: tb/tb.sv */
// self-checking bench for the safety gate monitor
`timescale 1ns/1ps
`default_nettype none
`include "sgm_defs.vh"
module tb;
  logic clk = 0, rst = 1, run = 0, trig = 0, wr = 0, rd = 0;
  logic [3:0] addr = 0, bad = 0, gin;
  logic [15:0] wdat = 0;
  logic [1:0] shut = 0;
  wire [15:0] rdat;
  wire ok, flt, m1, m2, pend, skw, tf;
  wire [6:0] st = {tf, skw, pend, m2, m1, flt, ok};
  int fail_count = 0, n_tests = 0, t, p;
  sgm_door door (.clk_i(clk), .shut_i(shut), .comp_i(1'b0), .bad_i(bad), .gate_o(gin));
  sgm_top #(.TICK_CYCLES(4)) dut (.SYS_CLK_I(clk), .RESET_I(rst), .GATE_IN_I(gin),
    .RUN_MODE_I(run), .TEST_TRIG_I(trig), .ADDR_I(addr), .WDATA_I(wdat), .WR_I(wr),
    .RD_I(rd), .RDATA_O(rdat), .GATE_OK_O(ok), .FAULT_O(flt), .P1_MISMATCH_O(m1),
    .P2_MISMATCH_O(m2), .TEST_PENDING_O(pend), .SKEW_FAULT_O(skw), .TEST_FAIL_O(tf));
  initial begin
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic look(input logic [6:0] e);
    chk({9'h000, st}, {9'h000, e});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // bounded wait on one status bit; a miss shows in the compare after it
  task automatic wait_st(input int k, input logic v);
    int n;
    for (n = 0; n < 60 && st[k] !== v; n++) begin
      @(posedge clk);
      #1;
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1;
    addr <= a;
    wdat <= d;
    @(posedge clk);
    wr <= 0;
  endtask
  task automatic rreg(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    rd <= 1;
    addr <= a;
    @(posedge clk);
    rd <= 0;
    #1;
    chk(rdat, e);
  endtask
  task automatic drive(input logic [1:0] s, input logic [3:0] b);
    @(posedge clk);
    shut <= s;
    bad <= b;
  endtask
  function automatic logic act(input int ty, input logic [3:0] g);
    case (ty)
      0: return g[0];
      1: return g[0] & g[1];
      2: return g[0] & ~g[1];
      3: return &g;
      default: return g == 4'h5;
    endcase
  endfunction
  task automatic final_report;
    if (fail_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #200000;
    fail_count++;
    final_report;
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 0;
    rreg(`SGM_OFS_CTRL, 16'h0001);
    rreg(`SGM_OFS_DISC1, 16'h0003);
    rreg(`SGM_OFS_DISC2, 16'h0003);
    rreg(`SGM_OFS_SYNC, 16'h001e);
    rreg(4'h5, 16'h0000);
    wreg(`SGM_OFS_STATUS, 16'hffff);
    rreg(`SGM_OFS_STATUS, 16'h0000);
    wreg(`SGM_OFS_DISC1, 16'hffff);
    rreg(`SGM_OFS_DISC1, 16'h0bb8);
    wreg(`SGM_OFS_DISC1, 16'h0000);
    wreg(`SGM_OFS_DISC2, 16'h0000);
    wreg(`SGM_OFS_SYNC, 16'h0000);
    run <= 1;
    for (t = 0; t < 5; t++) begin
      wreg(`SGM_OFS_CTRL, {13'h007e, t[2:0]});
      for (p = 0; p < 16; p++) begin
        drive(2'h0, p[3:0]);
        cyc(3);
        chk(ok, act(t, p[3:0]));
      end
    end
    wreg(`SGM_OFS_CTRL, 16'h03f1);
    wreg(`SGM_OFS_DISC1, 16'h0002);
    drive(2'h3, 4'h0);
    cyc(4);
    look(7'h01);
    drive(2'h3, 4'h2);
    cyc(3);
    look(7'h00);
    wait_st(2, 1);
    look(7'h06);
    rreg(`SGM_OFS_STATUS, 16'h0006);
    drive(2'h0, 4'h0);
    cyc(4);
    look(7'h06);
    drive(2'h3, 4'h0);
    wait_st(0, 1);
    look(7'h01);
    wreg(`SGM_OFS_DISC1, 16'h0000);
    drive(2'h3, 4'h2);
    cyc(40);
    look(7'h00);
    wreg(`SGM_OFS_DISC1, 16'h0001);
    wait_st(2, 1);
    @(posedge clk);
    run <= 0;
    cyc(3);
    @(posedge clk);
    run <= 1;
    cyc(2);
    look(7'h00);
    wait_st(2, 1);
    wreg(`SGM_OFS_CTRL, 16'h03f3);
    wreg(`SGM_OFS_DISC1, 16'h0000);
    drive(2'h0, 4'h0);
    cyc(4);
    look(7'h06);
    drive(2'h1, 4'h0);
    cyc(4);
    look(7'h06);
    drive(2'h3, 4'h0);
    wait_st(0, 1);
    look(7'h01);
    wreg(`SGM_OFS_SYNC, 16'h0002);
    drive(2'h0, 4'h0);
    cyc(3);
    drive(2'h1, 4'h0);
    wait_st(5, 1);
    look(7'h22);
    drive(2'h0, 4'h0);
    cyc(3);
    drive(2'h3, 4'h0);
    wait_st(0, 1);
    look(7'h01);
    wreg(`SGM_OFS_SYNC, 16'h0000);
    wreg(`SGM_OFS_DISC2, 16'h0001);
    drive(2'h3, 4'h8);
    wait_st(3, 1);
    look(7'h0a);
    drive(2'h3, 4'h0);
    run <= 0;
    wreg(`SGM_OFS_CTRL, 16'h03f8);
    run <= 1;
    cyc(4);
    look(7'h10);
    drive(2'h0, 4'h0);
    cyc(3);
    look(7'h10);
    drive(2'h3, 4'h0);
    wait_st(0, 1);
    look(7'h01);
    @(posedge clk);
    trig <= 1;
    @(posedge clk);
    trig <= 0;
    cyc(2);
    chk(pend, 1'b1);
    @(posedge clk);
    trig <= 1;
    @(posedge clk);
    trig <= 0;
    cyc(2);
    chk({tf, flt, ok}, 3'h6);
    wreg(`SGM_OFS_CTRL, 16'h0008);
    cyc(1);
    look(7'h00);
    rreg(`SGM_OFS_STATUS, 16'h0062);
    wreg(`SGM_OFS_CTRL, 16'h03f8);
    cyc(1);
    look(7'h52);
    drive(2'h0, 4'h0);
    cyc(3);
    drive(2'h3, 4'h0);
    wait_st(0, 1);
    look(7'h01);
    @(posedge clk);
    run <= 0;
    cyc(3);
    chk(ok, 1'b0);
    final_report;
  end
endmodule // tb
bind sgm_top sgm_chk chk_u (.SYS_CLK_I, .RESET_I, .GATE_IN_I, .RUN_MODE_I, .ADDR_I,
  .WDATA_I, .WR_I, .GATE_OK_O, .FAULT_O, .P1_MISMATCH_O, .P2_MISMATCH_O,
  .TEST_PENDING_O, .SKEW_FAULT_O, .TEST_FAIL_O);
`default_nettype wire
